// file: design/scbu_branch_unit.sv
// branch resolution for signed compare-with-zero branches
// assumes operands and instruction valid on REF_CLK while INSTR_VALID is high
`timescale 1ns/1ps
`include "scbu_defines.svh"
module scbu_branch_unit (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        INSTR_VALID,
  input  wire logic [31:0] INSTR,
  input  wire logic [31:0] PC,
  input  wire logic [31:0] TESTED_SOURCE_REG,
  input  wire logic [31:0] OFFSET_SOURCE_REG,
  output logic             IS_BRANCH,
  output logic             STALL,
  output logic             BRANCH_DONE,
  output logic             TAKEN,
  output logic             DELAY_SLOT,
  output logic [31:0]      NEXT_PC,
  output logic [1:0]       CYCLES
);
  import scbu_pkg::*;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function automatic scbu_cond_t dec_cond(input logic [3:0] code);
    case (code)
      `SCBU_COND_GT: dec_cond = SCBU_C_GT;
      `SCBU_COND_LE: dec_cond = SCBU_C_LE;
      `SCBU_COND_LT: dec_cond = SCBU_C_LT;
      default:       dec_cond = SCBU_C_NONE;
    endcase
  endfunction : dec_cond

  function automatic logic eval_cond(input scbu_cond_t         c,
                                     input logic signed [31:0] v);
    case (c)
      SCBU_C_GT: eval_cond = (v > 32'sh0);
      SCBU_C_LE: eval_cond = (v <= 32'sh0);
      SCBU_C_LT: eval_cond = (v < 32'sh0);
      default:   eval_cond = 1'b0;
    endcase
  endfunction : eval_cond

  function automatic logic [31:0] pc_add(input logic [31:0] base,
                                         input logic [31:0] step);
    pc_add = base + step;
  endfunction : pc_add

  function automatic logic [1:0] busy_len(input logic dly);
    busy_len = dly ? `SCBU_LEFT_DELAY : `SCBU_LEFT_NODELAY;
  endfunction : busy_len

  // ----------------------------------------
  // decode
  // ----------------------------------------
  scbu_state_t        state_q;
  scbu_state_t        state_d;
  logic [5:0]         opc;
  logic               is_reg;
  logic               is_imm;
  logic               is_prefix;
  logic               is_branch;
  logic               accept;
  scbu_cond_t         cond;
  logic               cond_true;
  logic signed [31:0] tested_s;
  logic [31:0]        imm_op;
  logic [31:0]        offset;

  logic               prefix_q;
  logic               prefix_d;
  logic [15:0]        prefix_hi_q;
  logic [15:0]        prefix_hi_d;

  always_comb begin
    opc       = INSTR[`SCBU_OPC_HI:`SCBU_OPC_LO];
    cond      = dec_cond(INSTR[`SCBU_COND_HI:`SCBU_COND_LO]);
    is_reg    = (opc == `SCBU_OPC_REG) && (cond != SCBU_C_NONE);
    is_imm    = (opc == `SCBU_OPC_IMM) && (cond != SCBU_C_NONE);
    is_prefix = (opc == `SCBU_OPC_PREFIX);
    is_branch = INSTR_VALID && (is_reg || is_imm);
    accept    = INSTR_VALID && (state_q == SCBU_S_IDLE);
  end

  // ----------------------------------------
  // condition and operand
  // ----------------------------------------
  always_comb begin
    tested_s  = TESTED_SOURCE_REG;
    cond_true = eval_cond(cond, tested_s);
    if (prefix_q) begin
      imm_op = {prefix_hi_q, INSTR[`SCBU_IMM_HI:`SCBU_IMM_LO]};
    end else begin
      imm_op = {{16{INSTR[`SCBU_IMM_HI]}},
                INSTR[`SCBU_IMM_HI:`SCBU_IMM_LO]};
    end
    offset = is_imm ? imm_op : OFFSET_SOURCE_REG;
  end

  // ----------------------------------------
  // prefix tracking
  // ----------------------------------------
  always_comb begin
    prefix_d    = prefix_q;
    prefix_hi_d = prefix_hi_q;
    if (accept) begin
      prefix_d = is_prefix;
      if (is_prefix) begin
        prefix_hi_d = INSTR[`SCBU_IMM_HI:`SCBU_IMM_LO];
      end
    end
  end

  // ----------------------------------------
  // prefix registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prefix_q    <= 1'b0;
      prefix_hi_q <= `SCBU_PREFIX_RESET;
    end else begin
      prefix_q    <= prefix_d;
      prefix_hi_q <= prefix_hi_d;
    end
  end

  // ----------------------------------------
  // branch sequencing
  // ----------------------------------------
  logic [1:0]  left_q;
  logic [1:0]  left_d;
  logic        taken_q;
  logic        taken_d;
  logic        dly_q;
  logic        dly_d;
  logic [31:0] npc_q;
  logic [31:0] npc_d;
  logic [1:0]  cyc_q;
  logic [1:0]  cyc_d;
  logic        done_q;
  logic        done_d;
  logic        dly_bit;

  always_comb begin
    dly_bit = INSTR[`SCBU_DLY_BIT];
    state_d = state_q;
    left_d  = left_q;
    taken_d = taken_q;
    dly_d   = dly_q;
    npc_d   = npc_q;
    cyc_d   = cyc_q;
    done_d  = 1'b0;
    case (state_q)
      SCBU_S_IDLE: begin
        if (is_branch) begin
          taken_d = cond_true;
          dly_d   = cond_true && dly_bit;
          if (cond_true) begin
            npc_d = pc_add(PC, offset);
            if (dly_bit) begin
              cyc_d = `SCBU_CYC_DELAY;
            end else begin
              cyc_d = `SCBU_CYC_NODELAY;
            end
          end else begin
            npc_d = pc_add(PC, `SCBU_PC_STEP);
            cyc_d = `SCBU_CYC_UNTAKEN;
          end
          if (cond_true) begin
            left_d  = busy_len(dly_bit);
            state_d = SCBU_S_BUSY;
          end else begin
            done_d = 1'b1;
          end
        end
      end
      SCBU_S_BUSY: begin
        left_d = left_q - 2'h1;
        if (left_q == 2'h1) begin
          state_d = SCBU_S_IDLE;
          done_d  = 1'b1;
        end
      end
      default: state_d = SCBU_S_IDLE;
    endcase
  end

  // ----------------------------------------
  // sequencing registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= SCBU_S_IDLE;
      left_q  <= `SCBU_LEFT_RESET;
      taken_q <= 1'b0;
      dly_q   <= 1'b0;
      npc_q   <= `SCBU_PC_RESET;
      cyc_q   <= `SCBU_CYC_RESET;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      left_q  <= left_d;
      taken_q <= taken_d;
      dly_q   <= dly_d;
      npc_q   <= npc_d;
      cyc_q   <= cyc_d;
      done_q  <= done_d;
    end
  end

  // ----------------------------------------
  // handshake outputs
  // ----------------------------------------
  assign IS_BRANCH   = is_branch;
  assign STALL       = (state_q == SCBU_S_BUSY) ||
                       (is_branch && cond_true);

  // ----------------------------------------
  // result outputs
  // ----------------------------------------
  assign BRANCH_DONE = done_q;
  assign TAKEN       = taken_q;
  assign DELAY_SLOT  = dly_q;
  assign NEXT_PC     = npc_q;
  assign CYCLES      = cyc_q;
endmodule : scbu_branch_unit

// file: design/scbu_defines.svh
// constants for the signed compare branch unit
// assumes lsb numbering of the instruction word, opcode in bits 31:26
`ifndef SCBU_DEFINES_SVH
`define SCBU_DEFINES_SVH
// ----------------------------------------
// instruction fields and constants, lsb numbering
// ----------------------------------------
`define SCBU_OPC_HI      31
`define SCBU_OPC_LO      26
`define SCBU_OPC_REG     6'h27
`define SCBU_OPC_IMM     6'h2f
`define SCBU_OPC_PREFIX  6'h2c
`define SCBU_DLY_BIT     25
`define SCBU_COND_HI     24
`define SCBU_COND_LO     21
`define SCBU_COND_LT     4'h2
`define SCBU_COND_LE     4'h3
`define SCBU_COND_GT     4'h4
`define SCBU_RA_HI       20
`define SCBU_RA_LO       16
`define SCBU_IMM_HI      15
`define SCBU_IMM_LO      0
`define SCBU_PC_STEP     32'h0000_0004
`define SCBU_CYC_UNTAKEN 2'h1
`define SCBU_CYC_DELAY   2'h2
`define SCBU_CYC_NODELAY 2'h3
`define SCBU_PC_RESET    32'h0000_0000
`define SCBU_PREFIX_RESET 16'h0000
`define SCBU_LEFT_RESET  2'h0
`define SCBU_CYC_RESET   2'h0
`define SCBU_LEFT_DELAY  2'h1
`define SCBU_LEFT_NODELAY 2'h2
`endif

// file: design/scbu_pkg.sv
// types for the signed compare branch unit
// assumes scbu_defines.svh is available on the include path
package scbu_pkg;
  typedef enum logic [1:0] {
    SCBU_C_NONE,
    SCBU_C_GT,
    SCBU_C_LE,
    SCBU_C_LT
  } scbu_cond_t;
  typedef enum logic [1:0] {
    SCBU_S_IDLE,
    SCBU_S_BUSY
  } scbu_state_t;
endpackage : scbu_pkg

// file: verif/scbu_chk_sva.sv
// concurrent checks on the branch unit ports
// assumes scbu_defines.svh on the include path
`timescale 1ns/1ps
`include "scbu_defines.svh"
module scbu_chk (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        INSTR_VALID,
  input wire logic [31:0] INSTR,
  input wire logic [31:0] PC,
  input wire logic [31:0] TESTED_SOURCE_REG,
  input wire logic [31:0] OFFSET_SOURCE_REG,
  input wire logic        IS_BRANCH,
  input wire logic        STALL,
  input wire logic        BRANCH_DONE,
  input wire logic        TAKEN,
  input wire logic        DELAY_SLOT,
  input wire logic [31:0] NEXT_PC,
  input wire logic [1:0]  CYCLES
);
  logic               busy_q, busy_d;
  logic               iss;
  logic [3:0]         cnd;
  logic signed [31:0] tst;
  assign iss = INSTR_VALID && IS_BRANCH && !busy_q;
  assign cnd = INSTR[24:21];
  assign tst = TESTED_SOURCE_REG;
  always_comb busy_d = (iss && STALL) ? 1'b1 : BRANCH_DONE ? 1'b0 : busy_q;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) busy_q <= 1'b0;
    else busy_q <= busy_d;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  untaken_done_a: assert property (
    iss && !STALL |=> BRANCH_DONE && CYCLES == 2'h1 && !TAKEN
    && NEXT_PC == $past(PC) + 32'h4) else $error("untaken result");
  delay_taken_a: assert property (
    iss && STALL && INSTR[25] |=> TAKEN && DELAY_SLOT && CYCLES == 2'h2
    && !BRANCH_DONE ##1 BRANCH_DONE) else $error("delay latency");
  nodelay_taken_a: assert property (
    iss && STALL && !INSTR[25] |=> TAKEN && !DELAY_SLOT && CYCLES == 2'h3
    && !BRANCH_DONE ##1 !BRANCH_DONE ##1 BRANCH_DONE)
    else $error("no delay latency");
  gt_cond_a: assert property (
    iss && cnd == `SCBU_COND_GT |-> STALL == (tst > 0)) else $error("gt");
  le_cond_a: assert property (
    iss && cnd == `SCBU_COND_LE |-> STALL == (tst <= 0)) else $error("le");
  lt_cond_a: assert property (
    iss && cnd == `SCBU_COND_LT |-> STALL == (tst < 0)) else $error("lt");
  reg_target_a: assert property (
    iss && STALL && INSTR[31:26] == `SCBU_OPC_REG |=> NEXT_PC ==
    $past(PC) + $past(OFFSET_SOURCE_REG)) else $error("reg target");
  cond_decode_a: assert property (
    IS_BRANCH == (INSTR_VALID && (INSTR[31:26] == `SCBU_OPC_REG
    || INSTR[31:26] == `SCBU_OPC_IMM) && cnd inside {`SCBU_COND_LT,
    `SCBU_COND_LE, `SCBU_COND_GT})) else $error("decode");
endmodule : scbu_chk
bind scbu_branch_unit scbu_chk u_chk (.*);

// file: verif/tb_signed_compare_branch_unit.sv
// self-checking bench for the branch unit
// assumes design files and scbu_defines.svh compiled first
`timescale 1ns/1ps
`include "scbu_defines.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_signed_compare_branch_unit;
  logic        REF_CLK = 0, RST_N = 0, INSTR_VALID = 0;
  logic [31:0] INSTR = 0, PC = 0;
  logic [31:0] TESTED_SOURCE_REG = 0, OFFSET_SOURCE_REG = 0;
  logic        IS_BRANCH, STALL, BRANCH_DONE, TAKEN, DELAY_SLOT;
  logic [31:0] NEXT_PC;
  logic [1:0]  CYCLES;
  int          num_errors = 0, compares = 0, cyc = 0;
  scbu_branch_unit uut (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .PC(PC),
    .TESTED_SOURCE_REG(TESTED_SOURCE_REG),
    .OFFSET_SOURCE_REG(OFFSET_SOURCE_REG), .IS_BRANCH(IS_BRANCH),
    .STALL(STALL), .BRANCH_DONE(BRANCH_DONE), .TAKEN(TAKEN),
    .DELAY_SLOT(DELAY_SLOT), .NEXT_PC(NEXT_PC), .CYCLES(CYCLES));
  initial forever #12.5 REF_CLK = ~REF_CLK;
  function automatic [31:0] mk(input [5:0] o, input d, input [3:0] c,
                               input [15:0] im);
    mk = {o, d, c, 5'h01, im};
  endfunction : mk
  task automatic br(input [31:0] ins, pc, a, b, epc, input [1:0] ec);
    int   n;
    logic s;
    @(posedge REF_CLK); #1;
    INSTR = ins; PC = pc; TESTED_SOURCE_REG = a; OFFSET_SOURCE_REG = b;
    INSTR_VALID = 1;
    #1 s = STALL;
    n = 0;
    do begin
      @(posedge REF_CLK); #1; n++;
      if (!s) INSTR_VALID = 0;
    end while (BRANCH_DONE !== 1'b1 && n < 6);
    if (s) INSTR_VALID = 0;
    `CHK("latency", ec, n)
    `CHK("CYCLES", ec, CYCLES)
    `CHK("NEXT_PC", epc, NEXT_PC)
    `CHK("TAKEN", ec != 2'h1, TAKEN)
    `CHK("DELAY_SLOT", ec == 2'h2, DELAY_SLOT)
  endtask : br
  task automatic t_cond;
    logic [31:0] v[5] = '{32'h1, 32'h0, 32'h8000_0000, 32'h7fff_ffff, '1};
    logic [3:0]  cs[3] = '{`SCBU_COND_LT, `SCBU_COND_LE, `SCBU_COND_GT};
    logic        tk;
    for (int c = 0; c < 3; c++) begin
      for (int d = 0; d < 2; d++) begin
        for (int i = 0; i < 5; i++) begin
          tk = c == 0 ? $signed(v[i]) < 0 : c == 1 ? $signed(v[i]) <= 0 :
               $signed(v[i]) > 0;
          br(mk(`SCBU_OPC_REG, d[0], cs[c], 16'h0),
             32'h1000, v[i], 32'h100, tk ? 32'h1100 : 32'h1004,
             !tk ? 1 : d ? 2 : 3);
        end
      end
    end
  endtask : t_cond
  task automatic t_imm;
    br(mk(`SCBU_OPC_IMM, 0, `SCBU_COND_GT, 16'h8000), 32'h2000, 5, 32'h40,
       32'hffff_a000, 3);
    br(mk(`SCBU_OPC_IMM, 1, `SCBU_COND_LT, 16'h0010), 32'h2000, '1, 32'h40,
       32'h2010, 2);
  endtask : t_imm
  task automatic t_pfx;
    @(posedge REF_CLK); #1;
    INSTR = {`SCBU_OPC_PREFIX, 10'h0, 16'h1234};
    INSTR_VALID = 1;
    br(mk(`SCBU_OPC_IMM, 0, `SCBU_COND_GT, 16'h8000), 32'h0, 5, 0,
       32'h1234_8000, 3);
    br(mk(`SCBU_OPC_IMM, 0, `SCBU_COND_GT, 16'h8000), 32'h0, 5, 0,
       32'hffff_8000, 3);
  endtask : t_pfx
  task automatic t_rst;
    @(posedge REF_CLK); #1;
    INSTR = {`SCBU_OPC_PREFIX, 10'h0, 16'h5678};
    INSTR_VALID = 1;
    @(posedge REF_CLK); #1;
    RST_N = 0;
    INSTR_VALID = 0;
    #1;
    `CHK("rst BRANCH_DONE", 1'b0, BRANCH_DONE)
    `CHK("rst TAKEN", 1'b0, TAKEN)
    `CHK("rst DELAY_SLOT", 1'b0, DELAY_SLOT)
    `CHK("rst NEXT_PC", 32'h0, NEXT_PC)
    `CHK("rst CYCLES", 2'h0, CYCLES)
    @(posedge REF_CLK); #1;
    RST_N = 1;
    br(mk(`SCBU_OPC_IMM, 1, `SCBU_COND_LE, 16'hfff0), 32'h100, 0, 0,
       32'h0000_00f0, 2);
  endtask : t_rst
  task automatic end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc > 2000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge REF_CLK);
    #1 RST_N = 1;
    t_cond();
    t_imm();
    t_pfx();
    t_rst();
    end_of_test();
  end
endmodule : tb_signed_compare_branch_unit
